// ### logic/adc_seq_defs.svh
// Offsets, field positions, reset values and timing counts of the converter sequencer.
// Assumes an 8-bit special function register port on the CPU machine clock.
//
// Behaviour
// RQ1: Outside select one flags results outside window.
// RQ2: Limits are symmetric; inside means exactly one below.
// RQ3: Software 0-to-1 start; busy holds until done.
// RQ4: Enabled external falling edge starts conversion.
// RQ5: Sixteen clocks: five sample, ten trials, end.
// RQ6: Interrupt on end, optionally qualified by match.
// RQ7: Software clears end flag after reading result.
// RQ8: Match flag updated at every conversion end.
// RQ9: Continuous mode restarts on the next cycle.
// RQ10: Leaving continuous mode finishes current conversion first.
// RQ11: Power off aborts conversion, clears busy.
// RQ12: Software waits warm-up after powering on.
// RQ13: All registers reset to zero.
// RQ14: High byte format follows alignment select.
// RQ15: Channel select applied when conversion starts.
// RQ16: Converter clock is machine clock over N+1.
// RQ17: Software sets the conversion interrupt enable.
// RQ18: Limits compare against top eight result bits.
// RQ19: Low byte always holds result bits 7-0.
// RQ20: Trials run bit 9 down to bit 0.
// RQ21: Results, match and end flag update together.
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// ==========================================================
// Register offsets
`define ADC_CTRL1_ADDR 8'hb2
`define ADC_CTRL2_ADDR 8'hb3
`define ADC_RESH_ADDR  8'hb4
`define ADC_RESL_ADDR  8'hb5
`define ADC_WINDOW_UPPER_LIMIT_ADDR 8'hb6
`define ADC_WINDOW_LOWER_LIMIT_ADDR 8'hb7

// ==========================================================
// Control one bit positions
`define ADC_C1_BUSY    7
`define ADC_C1_EOC     6
`define ADC_C1_CONT    5
`define ADC_C1_EXT     4
`define ADC_C1_QUAL    3
`define ADC_C1_MATCH   2
`define ADC_C1_POWER   1
`define ADC_C1_OUTSIDE 0

// ==========================================================
// Control two fields
`define ADC_C2_ALIGN   7
`define ADC_C2_CHAN_HI 6
`define ADC_C2_CHAN_LO 4
`define ADC_C2_PRE_HI  3
`define ADC_C2_PRE_LO  0

`define ADC_RESET_BYTE 8'h00

// ==========================================================
// Sequence timing in converter clocks
`define ADC_SAMPLE_CLKS 4'h5
`define ADC_LAST_STEP   4'hf
`define ADC_TOP_TRIAL   10'h200

`endif

// ### logic/adc_seq_pkg.sv
// Types shared by the converter sequencer and its prescaler.
// Assumes the defines header is compiled alongside.
package adc_seq_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } conv_state_t;

    // Software-visible control one bits that hardware does not own
    typedef struct packed {
        logic cont;
        logic ext_en;
        logic qual;
        logic power;
        logic outside;
    } ctrl1_t;

    typedef struct packed {
        conv_state_t state;
        logic [3:0]  step;
        logic [9:0]  sar;
        logic [9:0]  dac;
        logic [9:0]  result;
        logic [2:0]  chan_act;
        logic        busy;
        logic        eoc;
        logic        match;
        ctrl1_t      c1;
        logic [7:0]  ctrl2;
        logic [7:0]  win_hi;
        logic [7:0]  win_lo;
        logic [1:0]  ext_sync;
        logic        ext_prev;
        logic [7:0]  rdata;
    } seq_state_t;

    typedef struct packed {
        logic [3:0] cnt;
    } presc_state_t;

endpackage

// ### logic/adc_prescaler.sv
// Converter clock prescaler: one tick every N+1 machine clocks.
// Assumes clr is held while the sequencer is idle.
module adc_prescaler import adc_seq_pkg::*; #(
    parameter int PRESC_W = 4
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_b,
    // Control
    input  wire logic               clr,
    input  wire logic [PRESC_W-1:0] div_n,
    // Converter clock tick
    output logic                    tick
);

    if (PRESC_W != 4) begin : g_chk
        $error("adc_prescaler: PRESC_W must match the 4-bit field");
    end

    presc_state_t st;
    presc_state_t next_st;

    // ==========================================================
    // Divider
    always_comb begin
        next_st = st;
        if (clr || st.cnt == 4'h0) begin
            next_st.cnt = div_n; // [RQ16]
        end else begin
            next_st.cnt = st.cnt - 4'h1;
        end
    end

    assign tick = !clr && st.cnt == 4'h0; // [RQ16]

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

// ### logic/adc_sequencer_window_compare.sv
// Converter sequencer with window comparator and special function registers.
// Assumes the analog core compares dac_code against the held sample on clk.
`include "adc_seq_defs.svh"
module adc_sequencer_window_compare import adc_seq_pkg::*; #(
    parameter int PRESC_W = 4
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Special function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // External start pin
    input  wire logic       ext_start_b,
    // Interrupt
    input  wire logic       conv_irq_enable,
    output logic            conv_irq,
    // Analog core
    input  wire logic       cmp_le,
    output logic            ana_power,
    output logic            ana_sample,
    output logic      [2:0] ana_channel,
    output logic      [9:0] dac_code
);

    seq_state_t st;
    seq_state_t next_st;
    logic       tick;
    logic       presc_clr;
    logic       wr_c1;
    logic       ext_fall;
    logic       sw_start;
    logic       start_now;
    logic       in_win;
    logic       win_hit;
    logic [9:0] mask;
    logic [9:0] sar_kept;
    logic [7:0] c1_view;
    logic [7:0] resh_view;

    adc_prescaler #(
        .PRESC_W (PRESC_W)
    ) u_presc (
        .clk   (clk),
        .rst_b (rst_b),
        .clr   (presc_clr),
        .div_n (st.ctrl2[`ADC_C2_PRE_HI:`ADC_C2_PRE_LO]),
        .tick  (tick)
    );

    // ==========================================================
    // Window comparator on the top eight bits of the new result
    assign in_win  = (st.win_hi < st.sar[9:2]) ^ (st.win_lo < st.sar[9:2]); // [RQ2] [RQ18]
    assign win_hit = st.c1.outside ^ in_win; // [RQ1]

    // ==========================================================
    // Start sources
    assign wr_c1    = sfr_wr && sfr_addr == `ADC_CTRL1_ADDR;
    assign ext_fall = st.c1.ext_en && st.ext_prev && !st.ext_sync[1]; // [RQ4]
    assign sw_start = wr_c1 && sfr_wdata[`ADC_C1_BUSY] && !st.busy; // [RQ3]
    // A start with the converter unpowered is dropped: no sample could be taken
    assign start_now = st.state == ST_IDLE && st.c1.power && (sw_start || ext_fall);

    assign mask     = `ADC_TOP_TRIAL >> (st.step - `ADC_SAMPLE_CLKS); // [RQ20]
    assign sar_kept = cmp_le ? st.dac : st.sar; // [RQ20]

    assign presc_clr = st.state != ST_CONV;

    assign c1_view = {st.busy, st.eoc, st.c1.cont, st.c1.ext_en,
                      st.c1.qual, st.match, st.c1.power, st.c1.outside};
    assign resh_view = st.ctrl2[`ADC_C2_ALIGN] ? {6'h00, st.result[9:8]}
                                               : st.result[9:2]; // [RQ14]

    // ==========================================================
    // Next state
    always_comb begin
        next_st          = st;
        next_st.ext_sync = {st.ext_sync[0], ext_start_b};
        next_st.ext_prev = st.ext_sync[1];

        // Register writes
        if (sfr_wr) begin
            unique case (sfr_addr)
                `ADC_CTRL1_ADDR: begin
                    next_st.c1.cont    = sfr_wdata[`ADC_C1_CONT];
                    next_st.c1.ext_en  = sfr_wdata[`ADC_C1_EXT];
                    next_st.c1.qual    = sfr_wdata[`ADC_C1_QUAL];
                    next_st.c1.power   = sfr_wdata[`ADC_C1_POWER];
                    next_st.c1.outside = sfr_wdata[`ADC_C1_OUTSIDE];
                    next_st.eoc        = sfr_wdata[`ADC_C1_EOC];
                end
                `ADC_CTRL2_ADDR: next_st.ctrl2 = sfr_wdata;
                `ADC_RESH_ADDR: begin
                    if (st.ctrl2[`ADC_C2_ALIGN]) begin
                        next_st.result[9:8] = sfr_wdata[1:0];
                    end else begin
                        next_st.result[9:2] = sfr_wdata;
                    end
                end
                `ADC_RESL_ADDR: next_st.result[7:0] = sfr_wdata;
                `ADC_WINDOW_UPPER_LIMIT_ADDR: next_st.win_hi = sfr_wdata;
                `ADC_WINDOW_LOWER_LIMIT_ADDR: next_st.win_lo = sfr_wdata;
                default: begin
                end
            endcase
        end

        // Conversion sequence
        unique case (st.state)
            ST_IDLE: begin
                if (start_now) begin
                    next_st.state    = ST_CONV;
                    next_st.busy     = 1'b1; // [RQ3] [RQ4]
                    next_st.step     = 4'h0;
                    next_st.chan_act = st.ctrl2[`ADC_C2_CHAN_HI:`ADC_C2_CHAN_LO]; // [RQ15]
                end
            end
            ST_CONV: begin
                if (tick) begin
                    next_st.step = st.step + 4'h1; // [RQ5]
                    if (st.step == `ADC_SAMPLE_CLKS - 4'h1) begin
                        next_st.sar = 10'h000;
                        next_st.dac = `ADC_TOP_TRIAL; // [RQ20]
                    end else if (st.step >= `ADC_SAMPLE_CLKS && st.step < `ADC_LAST_STEP) begin
                        next_st.sar = sar_kept; // [RQ20]
                        next_st.dac = sar_kept | (mask >> 1);
                    end else if (st.step == `ADC_LAST_STEP) begin
                        next_st.result = st.sar; // [RQ21] [RQ19]
                        next_st.match  = win_hit; // [RQ8] [RQ21]
                        next_st.eoc    = 1'b1; // [RQ5] [RQ21]
                        next_st.step   = 4'h0;
                        if (st.c1.cont) begin
                            next_st.chan_act = st.ctrl2[`ADC_C2_CHAN_HI:`ADC_C2_CHAN_LO]; // [RQ9]
                        end else begin
                            next_st.state = ST_IDLE; // [RQ10]
                            next_st.busy  = 1'b0; // [RQ3]
                        end
                    end
                end
            end
            default: begin
                next_st.state = ST_IDLE;
            end
        endcase

        // Power-off abort outranks the state, busy and step updates above; a final-step result, match and end flag still land
        if (!next_st.c1.power) begin
            next_st.state = ST_IDLE; // [RQ11]
            next_st.busy  = 1'b0; // [RQ11]
            next_st.step  = 4'h0;
        end

        // Read data, answered one cycle after the address
        unique case (sfr_addr)
            `ADC_CTRL1_ADDR: next_st.rdata = c1_view;
            `ADC_CTRL2_ADDR: next_st.rdata = st.ctrl2;
            `ADC_RESH_ADDR:  next_st.rdata = resh_view; // [RQ14]
            `ADC_RESL_ADDR:  next_st.rdata = st.result[7:0]; // [RQ19]
            `ADC_WINDOW_UPPER_LIMIT_ADDR: next_st.rdata = st.win_hi;
            `ADC_WINDOW_LOWER_LIMIT_ADDR: next_st.rdata = st.win_lo;
            default:         next_st.rdata = `ADC_RESET_BYTE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st          <= '0; // [RQ13]
            st.state    <= ST_IDLE;
            st.ext_sync <= 2'b11;
            st.ext_prev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    assign sfr_rdata   = st.rdata;
    assign ana_power   = st.c1.power;
    assign ana_sample  = st.state == ST_CONV && st.step < `ADC_SAMPLE_CLKS; // [RQ5]
    assign ana_channel = st.chan_act;
    assign dac_code    = st.dac;
    assign conv_irq    = conv_irq_enable && st.eoc && (!st.c1.qual || st.match); // [RQ6]

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_outside_sel;
        st.state == ST_CONV && tick && st.step == `ADC_LAST_STEP && !sfr_wr
        |=> st.match == (st.c1.outside ^ ((st.win_hi < st.result[9:2])
                                         ^ (st.win_lo < st.result[9:2])));
    endproperty
    a_outside_sel: assert property (p_outside_sel) // [RQ1]
        else $error("match flag does not follow window rule");

    // Independent of the xor form: one limit below, the other at or above
    property p_symmetric;
        in_win == ((st.win_lo < st.sar[9:2] && st.win_hi >= st.sar[9:2])
                   || (st.win_hi < st.sar[9:2] && st.win_lo >= st.sar[9:2]));
    endproperty
    a_symmetric: assert property (p_symmetric) // [RQ2]
        else $error("inside test not symmetric");

    property p_busy_holds;
        st.busy && st.c1.power && !(tick && st.step == `ADC_LAST_STEP) && !(sfr_wr && sfr_addr
        == `ADC_CTRL1_ADDR && !sfr_wdata[`ADC_C1_POWER]) |=> st.busy;
    endproperty
    a_busy_holds: assert property (p_busy_holds) // [RQ3]
        else $error("busy dropped during conversion");

    property p_ext_start;
        st.state == ST_IDLE && st.c1.power && st.c1.ext_en && st.ext_prev && !st.ext_sync[1]
        && !(sfr_wr && sfr_addr == `ADC_CTRL1_ADDR) |=> st.busy && st.state == ST_CONV;
    endproperty
    a_ext_start: assert property (p_ext_start) // [RQ4]
        else $error("external falling edge did not start");

    property p_ext_ignored;
        st.state == ST_IDLE && !st.c1.ext_en && !(sfr_wr && sfr_addr == `ADC_CTRL1_ADDR)
        |=> !st.busy;
    endproperty
    a_ext_ignored: assert property (p_ext_ignored) // [RQ4]
        else $error("conversion started without a start");

    property p_eoc_step;
        $rose(st.eoc) && !$past(sfr_wr) |-> $past(st.step) == `ADC_LAST_STEP && $past(tick);
    endproperty
    a_eoc_step: assert property (p_eoc_step) // [RQ5]
        else $error("end flag set off the final clock");

    // Checked against the software view of the flags, not the internal fields
    property p_irq;
        conv_irq == (conv_irq_enable && c1_view[`ADC_C1_EOC]
                     && (!c1_view[`ADC_C1_QUAL] || c1_view[`ADC_C1_MATCH]));
    endproperty
    a_irq: assert property (p_irq) // [RQ6]
        else $error("interrupt qualification wrong");

    property p_cont_restart;
        st.state == ST_CONV && tick && st.step == `ADC_LAST_STEP && st.c1.cont && next_st.c1.power
        |=> st.state == ST_CONV && st.busy && st.step == 4'h0;
    endproperty
    a_cont_restart: assert property (p_cont_restart) // [RQ9]
        else $error("continuous mode did not restart");

    property p_single_halt;
        st.state == ST_CONV && tick && st.step == `ADC_LAST_STEP && !st.c1.cont
        |=> st.state == ST_IDLE && !st.busy;
    endproperty
    a_single_halt: assert property (p_single_halt) // [RQ10]
        else $error("single shot did not halt");

    property p_abort;
        !st.c1.power |-> st.state == ST_IDLE && !st.busy;
    endproperty
    a_abort: assert property (p_abort) // [RQ11]
        else $error("running while powered down");

    property p_format;
        sfr_addr == `ADC_RESH_ADDR ##1 $stable(st.result) && $stable(st.ctrl2)
        |-> sfr_rdata == (st.ctrl2[`ADC_C2_ALIGN] ? {6'h00, st.result[9:8]} : st.result[9:2]);
    endproperty
    a_format: assert property (p_format) // [RQ14]
        else $error("high byte format wrong");

    property p_start_write;
        st.state == ST_IDLE && st.c1.power && sfr_wr && sfr_addr == `ADC_CTRL1_ADDR
        && sfr_wdata[`ADC_C1_BUSY] && sfr_wdata[`ADC_C1_POWER]
        |=> st.busy && st.state == ST_CONV;
    endproperty
    a_start_write: assert property (p_start_write) // [RQ3]
        else $error("software start did not begin a conversion");

    property p_chan_latch;
        $rose(st.busy) |-> ana_channel == $past(st.ctrl2[`ADC_C2_CHAN_HI:`ADC_C2_CHAN_LO]);
    endproperty
    a_chan_latch: assert property (p_chan_latch) // [RQ15]
        else $error("channel not taken at conversion start");

    // Sampling must close exactly as the first trial opens on bit 9
    property p_first_trial;
        st.state == ST_CONV && tick && st.step == `ADC_SAMPLE_CLKS - 4'h1
        |=> !ana_sample && dac_code == `ADC_TOP_TRIAL;
    endproperty
    a_first_trial: assert property (p_first_trial) // [RQ20]
        else $error("trials do not open at the top bit");

    property p_low_byte;
        sfr_addr == `ADC_RESL_ADDR ##1 $stable(st.result) |-> sfr_rdata == st.result[7:0];
    endproperty
    a_low_byte: assert property (p_low_byte) // [RQ19]
        else $error("low byte does not follow result");

    property p_result_with_eoc;
        $rose(st.eoc) && !$past(sfr_wr) |-> st.result == $past(st.sar);
    endproperty
    a_result_with_eoc: assert property (p_result_with_eoc) // [RQ21]
        else $error("result not updated with end flag");

    c_single: cover property (st.state == ST_CONV ##1 st.state == ST_IDLE && st.eoc);
    c_cont: cover property (tick && st.step == `ADC_LAST_STEP && st.c1.cont);
    c_abort: cover property (st.busy ##1 !st.busy && !st.c1.power);
    c_qual_irq: cover property (conv_irq && st.c1.qual);
    c_ext_start: cover property (st.c1.ext_en && $rose(st.busy));

endmodule

// ### sim/adc_core_model.sv
// Behavioural analog core: one sample-hold fed from the selected channel, and trial comparator.
// Assumes the sequencer holds ana_sample high only while sampling.
module adc_core_model (
    // Clock
    input  wire logic            clk,
    // Converter control
    input  wire logic            ana_power,
    input  wire logic            ana_sample,
    input  wire logic [2:0]      ana_channel,
    input  wire logic [9:0]      dac_code,
    // Input codes, one per channel
    input  wire logic [7:0][9:0] vin,
    // Comparator answer
    output logic                 cmp_le
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] held = 10'h000;
    logic       junk = 1'b0;
    always @(posedge clk) begin
        if (ana_sample) begin
            held <= vin[ana_channel];
        end
        junk <= ~junk;
    end
    // Unpowered comparator is meaningless, so it toggles rather than hold a value
    assign cmp_le = ana_power ? (dac_code <= held) : junk;
endmodule

// ### sim/adc_sequencer_window_compare_tb.sv
// Self-checking bench: register tasks, reference model, analog core model.
// Assumes the design files and adc_core_model are compiled first.
`include "adc_seq_defs.svh"
module adc_sequencer_window_compare_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WARM = 20;
    logic            clk = 1'b0, rst_b = 1'b0, sfr_wr = 1'b0;
    logic            ext_start_b = 1'b1, irq_en = 1'b0, cmp_le, conv_irq;
    logic      [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic            ana_power, ana_sample;
    logic      [2:0] ana_channel;
    logic      [9:0] dac_code;
    logic [7:0][9:0] vin = '0;
    int              error_cnt = 0, total_checks = 0, cyc = 0, hi, lo, r;
    bit              cont, ext, qual, pwr, outside, align;
    logic      [7:0] d;
    int              exp_q[$];

    always #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    adc_sequencer_window_compare dut (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .ext_start_b(ext_start_b), .conv_irq_enable(irq_en), .conv_irq(conv_irq),
        .cmp_le(cmp_le), .ana_power(ana_power), .ana_sample(ana_sample),
        .ana_channel(ana_channel), .dac_code(dac_code));
    adc_core_model core (.clk(clk), .ana_power(ana_power), .ana_sample(ana_sample),
        .ana_channel(ana_channel), .dac_code(dac_code), .vin(vin), .cmp_le(cmp_le));

    // ==========================================================
    // Compare and bus tasks
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_reg({7'h00, got}, {7'h00, exp});
    endtask
    function automatic logic [7:0] c1(input logic b);
        return {b, 1'b0, cont, ext, qual, 1'b0, pwr, outside};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        sfr_addr  <= a;
        sfr_wr    <= 1'b1;
        sfr_wdata <= v;
        @(posedge clk);
        sfr_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        sfr_addr <= a;
        @(posedge clk);
        #1 v = sfr_rdata;
    endtask
    task automatic wait_eoc;
        int t;
        t = 0;
        do begin
            rd(`ADC_CTRL1_ADDR, d);
            t++;
        end while (d[6] !== 1'b1 && t < 2000);
        chk_bit(t < 2000, 1'b1);
    endtask
    task automatic check_result;
        bit m;
        r = exp_q.pop_front();
        m = outside ^ (hi < r / 4) ^ (lo < r / 4);
        rd(`ADC_RESL_ADDR, d);
        chk_reg(d, r[7:0]);
        rd(`ADC_RESH_ADDR, d);
        chk_reg(d, align ? {6'h00, r[9:8]} : r[9:2]);
        rd(`ADC_CTRL1_ADDR, d);
        chk_bit(d[2], m);
        chk_bit(conv_irq, irq_en & (~qual | m));
        wr(`ADC_CTRL1_ADDR, c1(1'b0));
        rd(`ADC_CTRL1_ADDR, d);
        chk_bit(conv_irq, 1'b0);
    endtask

    // ==========================================================
    // One conversion with random channel, prescale, limits and format
    task automatic conv(input bit use_ext);
        int n, ch, t0;
        ch = $urandom % 8;
        n = $urandom % 16;
        r = $urandom % 1024;
        exp_q.push_back(r);
        hi = ($urandom % 3 == 0) ? r / 4 : $urandom % 256;
        lo = $urandom % 256;
        {outside, qual, align} = 3'($urandom);
        @(posedge clk);
        irq_en <= 1'($urandom);
        vin[ch] <= r[9:0];
        wr(`ADC_CTRL2_ADDR, {align, ch[2:0], n[3:0]});
        wr(`ADC_WINDOW_UPPER_LIMIT_ADDR, hi[7:0]);
        wr(`ADC_WINDOW_LOWER_LIMIT_ADDR, lo[7:0]);
        ext = use_ext;
        if (use_ext) begin
            wr(`ADC_CTRL1_ADDR, c1(1'b0));
            ext_start_b <= 1'b0;
            @(posedge clk) ext_start_b <= 1'b1;
        end else begin
            wr(`ADC_CTRL1_ADDR, c1(1'b1));
        end
        #1 t0 = cyc;
        repeat (6) @(posedge clk);
        rd(`ADC_CTRL1_ADDR, d);
        chk_bit(d[7], 1'b1);
        chk_reg({5'h00, ana_channel}, ch[7:0]);
        wr(`ADC_CTRL1_ADDR, c1(1'b0));
        rd(`ADC_CTRL1_ADDR, d);
        chk_bit(d[7], 1'b1);
        wait_eoc();
        if (!use_ext) begin
            chk_bit(cyc - t0 >= 16 * (n + 1) && cyc - t0 <= 16 * (n + 1) + 6, 1'b1);
        end
        check_result();
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #6000000;
        error_cnt++;
        $display("[ERR] %0t watchdog %h %h", $time, 8'h01, 8'h00);
        tally_and_finish();
    end

    initial begin
        void'($urandom(90));
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        for (int a = 8'hb2; a <= 8'hb8; a++) begin
            rd(a[7:0], d);
            chk_reg(d, 8'h00);
        end
        $display("test reset done");
        pwr = 1'b1;
        wr(`ADC_CTRL1_ADDR, c1(1'b0));
        repeat (WARM) @(posedge clk);
        for (int i = 0; i < 12; i++) begin
            conv(i % 3 == 2);
        end
        $display("test conversions done");
        cont = 1'b1;
        exp_q.push_back(r);
        ext = 1'b0;
        wr(`ADC_CTRL1_ADDR, c1(1'b1));
        wait_eoc();
        rd(`ADC_CTRL1_ADDR, d);
        chk_bit(d[7], 1'b1);
        cont = 1'b0;
        wr(`ADC_CTRL1_ADDR, c1(1'b0));
        wait_eoc();
        chk_bit(d[7], 1'b0);
        repeat (40) @(posedge clk);
        rd(`ADC_CTRL1_ADDR, d);
        chk_bit(d[7], 1'b0);
        check_result();
        $display("test continuous done");
        @(posedge clk) ext_start_b <= 1'b0;
        repeat (2) @(posedge clk);
        ext_start_b <= 1'b1;
        repeat (10) @(posedge clk);
        rd(`ADC_CTRL1_ADDR, d);
        chk_bit(d[7], 1'b0);
        $display("test pin ignored done");
        wr(`ADC_CTRL2_ADDR, 8'h0f);
        wr(`ADC_CTRL1_ADDR, c1(1'b1));
        repeat (40) @(posedge clk);
        pwr = 1'b0;
        wr(`ADC_CTRL1_ADDR, c1(1'b0));
        rd(`ADC_CTRL1_ADDR, d);
        chk_bit(d[7], 1'b0);
        chk_bit(ana_power, 1'b0);
        repeat (300) @(posedge clk);
        rd(`ADC_CTRL1_ADDR, d);
        chk_bit(d[6], 1'b0);
        $display("test abort done");
        tally_and_finish();
    end
endmodule
